//--- src/pcp_pkg.sv
// constants and types for the program counter and paging core
// How it works
// - counter width is 9, 10 or 11 bits by variant, for 512, 1K, 2K words
// - fetch addresses beyond implemented memory wrap to an implemented location
// - reset starts at the top location: 1FFh, 3FFh or 7FFh
// - a no-op at the reset vector advances and wraps to 000h
// - counter holds next address and increments each cycle unless loaded
// - jump loads counter bits 8 to 0 from the nine-bit address field
// - above 512 words, status bit 5 gives counter bit 9; at 2K words status bit 6 also gives bit 10
// - call or low-byte write loads bits 7 to 0 and clears bit 8
// - counter low byte in data memory maps onto counter bits 7 to 0
// - move, add or bit-set to the low byte act as computed jumps
// - above 512 words pages come from one or two status bits
// - above 32 registers, data banks come from file select register bits
// - config-load copies working register into 6-bit write-only config; top bits zero
// - reset sets config bits 5 to 0 to one
// - config bit 5: one counts external timer pin, zero counts cycle clock
// - config bit 4: one counts falling edges, zero rising edges
// - config bit 3: one gives prescaler to watchdog, zero to timer
// - rate codes 000..111 give timer 1:2..1:256, watchdog 1:1..1:128
package pcp_pkg;
  localparam int          PC_W_512      = 9;
  localparam int          PC_W_1K       = 10;
  localparam int          PC_W_2K       = 11;
  localparam int          PC_W_MAX      = 11;
  localparam logic [10:0] RESET_VEC_512 = 11'h1FF;
  localparam logic [10:0] RESET_VEC_1K  = 11'h3FF;
  localparam logic [10:0] RESET_VEC_2K  = 11'h7FF;
  localparam logic [7:0]  ADDR_LOW_BYTE = 8'h02;
  localparam logic [7:0]  ADDR_STATUS   = 8'h03;
  localparam logic [7:0]  ADDR_FILE_SEL = 8'h04;
  localparam int          STAT_PAGE_LO  = 5;
  localparam int          STAT_PAGE_HI  = 6;
  localparam int          FSEL_BANK_LO  = 5;
  localparam int          FSEL_BANK_HI  = 6;
  localparam logic [5:0]  CFG_RESET     = 6'h3F;
  localparam int          CFG_SRC_BIT   = 5;
  localparam int          CFG_EDGE_BIT  = 4;
  localparam int          CFG_ASSIGN_BIT = 3;
  localparam int          DATA_REGS_SMALL = 32;
  typedef enum logic [1:0] {
    PCP_V512 = 2'b00,
    PCP_V1K  = 2'b01,
    PCP_V2K  = 2'b10
  } pcp_variant_e;
  typedef enum logic [2:0] {
    PCP_OP_NONE  = 3'b000,
    PCP_OP_JUMP  = 3'b001,
    PCP_OP_CALL  = 3'b010,
    PCP_OP_LOWWR = 3'b011,
    PCP_OP_CFG   = 3'b100
  } pcp_op_e;
endpackage

//--- src/pcp_core.sv
// program counter, paging, banking and prescaler configuration
`timescale 1ns/1ps
module pcp_core #(
  parameter pcp_pkg::pcp_variant_e VARIANT   = pcp_pkg::PCP_V2K,
  parameter int                    DATA_REGS = 72
) (
  input  wire logic             I_CLK,
  input  wire logic             I_RST_B,
  input  wire pcp_pkg::pcp_op_e I_OP,
  input  wire logic [8:0]       I_INSTR_ADDR,
  input  wire logic [7:0]       I_RESULT,
  input  wire logic [7:0]       I_W_REG,
  input  wire logic [7:0]       I_STATUS,
  input  wire logic             I_FILE_WR,
  input  wire logic [7:0]       I_FILE_ADDR,
  input  wire logic [7:0]       I_FILE_WDATA,
  output logic [10:0]           O_INSTRUCTION_POINTER,
  output logic [7:0]            O_COUNTER_LOW_BYTE,
  output logic [1:0]            O_DATA_BANK,
  output logic                  O_TIMER_SRC_SEL,
  output logic                  O_TIMER_EDGE_SEL,
  output logic                  O_PRESCALER_ASSIGN,
  output logic [2:0]            O_PRESCALE_RATE,
  output logic [8:0]            O_TIMER_DIV_RATIO,
  output logic [7:0]            O_WDOG_DIV_RATIO
);
  import pcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // variant sizing
  localparam int PC_W = (VARIANT == PCP_V512) ? PC_W_512 :
                        (VARIANT == PCP_V1K) ? PC_W_1K : PC_W_2K;
  localparam logic [10:0] PC_MASK = 11'(({PC_W_MAX{1'b1}}) >> (PC_W_MAX - PC_W));
  localparam logic [10:0] RESET_VEC = (VARIANT == PCP_V512) ? RESET_VEC_512 :
                                      (VARIANT == PCP_V1K) ? RESET_VEC_1K : RESET_VEC_2K;

  function automatic logic [10:0] wrap_pc(input logic [10:0] a);
    wrap_pc = a & PC_MASK;
  endfunction

  function automatic logic [1:0] page_bits(input logic [7:0] st);
    if (VARIANT == PCP_V512) begin
      page_bits = 2'h0;
    end else if (VARIANT == PCP_V1K) begin
      page_bits = {1'b0, st[STAT_PAGE_LO]};
    end else begin
      page_bits = {st[STAT_PAGE_HI], st[STAT_PAGE_LO]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset synchroniser
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_b = rst_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // program counter
  logic [10:0] pc_r;
  logic [10:0] pc_nxt;
  wire         low_wr = (I_OP == PCP_OP_LOWWR) ||
                        (I_FILE_WR && (I_FILE_ADDR[4:0] == ADDR_LOW_BYTE[4:0]));
  wire  [7:0]  low_val = (I_OP == PCP_OP_LOWWR) ? I_RESULT : I_FILE_WDATA;

  always_comb begin
    pc_nxt = wrap_pc(pc_r + 11'h001);
    if (I_OP == PCP_OP_JUMP) begin
      pc_nxt = wrap_pc({page_bits(I_STATUS), I_INSTR_ADDR});
    end else if (I_OP == PCP_OP_CALL) begin
      pc_nxt = wrap_pc({page_bits(I_STATUS), 1'b0, I_INSTR_ADDR[7:0]});
    end else if (low_wr) begin
      pc_nxt = wrap_pc({page_bits(I_STATUS), 1'b0, low_val});
    end
  end

  always_ff @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= RESET_VEC;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data bank select
  logic [1:0] bank_r;
  always_ff @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      bank_r <= 2'h0;
    end else if (I_FILE_WR && (I_FILE_ADDR[4:0] == ADDR_FILE_SEL[4:0]) && (DATA_REGS > DATA_REGS_SMALL)) begin
      bank_r <= I_FILE_WDATA[FSEL_BANK_HI:FSEL_BANK_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler configuration
  logic [5:0] cfg_r;
  always_ff @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= CFG_RESET;
    end else if (I_OP == PCP_OP_CFG) begin
      cfg_r <= I_W_REG[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  always_ff @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      O_INSTRUCTION_POINTER <= RESET_VEC;
      O_COUNTER_LOW_BYTE    <= RESET_VEC[7:0];
      O_DATA_BANK           <= 2'h0;
      O_TIMER_SRC_SEL       <= CFG_RESET[CFG_SRC_BIT];
      O_TIMER_EDGE_SEL      <= CFG_RESET[CFG_EDGE_BIT];
      O_PRESCALER_ASSIGN    <= CFG_RESET[CFG_ASSIGN_BIT];
      O_PRESCALE_RATE       <= CFG_RESET[2:0];
      O_TIMER_DIV_RATIO     <= 9'h002 << CFG_RESET[2:0];
      O_WDOG_DIV_RATIO      <= 8'h01 << CFG_RESET[2:0];
    end else begin
      O_INSTRUCTION_POINTER <= pc_nxt;
      O_COUNTER_LOW_BYTE    <= pc_nxt[7:0];
      O_DATA_BANK           <= bank_r;
      O_TIMER_SRC_SEL       <= cfg_r[CFG_SRC_BIT];
      O_TIMER_EDGE_SEL      <= cfg_r[CFG_EDGE_BIT];
      O_PRESCALER_ASSIGN    <= cfg_r[CFG_ASSIGN_BIT];
      O_PRESCALE_RATE       <= cfg_r[2:0];
      O_TIMER_DIV_RATIO     <= 9'h002 << cfg_r[2:0];
      O_WDOG_DIV_RATIO      <= 8'h01 << cfg_r[2:0];
    end
  end
endmodule

//--- bench/pcp_core_sva.sv
// assertions for the program counter and paging core
`timescale 1ns/1ps
module pcp_core_sva (
  input wire logic              I_CLK,
  input wire logic              I_RST_B,
  input wire pcp_pkg::pcp_op_e  I_OP,
  input wire logic [8:0]        I_INSTR_ADDR,
  input wire logic [7:0]        I_RESULT,
  input wire logic [7:0]        I_W_REG,
  input wire logic [7:0]        I_STATUS,
  input wire logic              I_FILE_WR,
  input wire logic [10:0]       O_INSTRUCTION_POINTER,
  input wire logic [7:0]        O_COUNTER_LOW_BYTE,
  input wire logic              O_TIMER_SRC_SEL,
  input wire logic [2:0]        O_PRESCALE_RATE,
  input wire logic [8:0]        O_TIMER_DIV_RATIO
);
  import pcp_pkg::*;
  logic [2:0]  up_r;
  logic [10:0] ip;
  logic [1:0]  pg;
  assign ip = O_INSTRUCTION_POINTER;
  assign pg = I_STATUS[6:5];
  // settle count after reset release
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B || up_r != 3'h7);
  ////////////////////////////////////////////////////////////////
  property p_inc; $past(I_OP) == PCP_OP_NONE && !$past(I_FILE_WR) |-> ip == $past(ip) + 11'h1; endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_jmp; $past(I_OP) == PCP_OP_JUMP |-> ip == {$past(pg), $past(I_INSTR_ADDR)}; endproperty
  a_jmp: assert property (p_jmp) else $error("jump load wrong");
  property p_call; $past(I_OP) == PCP_OP_CALL |-> ip == {$past(pg), 1'b0, $past(I_INSTR_ADDR[7:0])}; endproperty
  a_call: assert property (p_call) else $error("call load wrong");
  property p_lwr; $past(I_OP) == PCP_OP_LOWWR |-> ip == {$past(pg), 1'b0, $past(I_RESULT)}; endproperty
  a_lwr: assert property (p_lwr) else $error("computed jump wrong");
  property p_map; O_COUNTER_LOW_BYTE == ip[7:0]; endproperty
  a_map: assert property (p_map) else $error("low byte mismatch");
  property p_rat; O_TIMER_DIV_RATIO == 9'h002 << O_PRESCALE_RATE; endproperty
  a_rat: assert property (p_rat) else $error("timer ratio wrong");
  property p_cfg; $past(I_OP, 2) == PCP_OP_CFG && $past(I_OP) != PCP_OP_CFG
    |-> {O_TIMER_SRC_SEL, O_PRESCALE_RATE} == {$past(I_W_REG[5], 2), $past(I_W_REG[2:0], 2)}; endproperty
  a_cfg: assert property (p_cfg) else $error("config load wrong");
  property p_rst; @(posedge I_CLK) disable iff (!I_RST_B)
    $rose(I_RST_B) |-> ip == 11'h7FF && O_TIMER_SRC_SEL; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  c_jmp: cover property ($past(I_OP) == PCP_OP_JUMP);
  c_wrap: cover property ($past(ip) == 11'h7FF && ip == 11'h000);
  c_cfg: cover property ($past(I_OP) == PCP_OP_CFG);
endmodule
bind pcp_core pcp_core_sva u_sva (.I_CLK, .I_RST_B, .I_OP, .I_INSTR_ADDR, .I_RESULT, .I_W_REG, .I_STATUS,
  .I_FILE_WR, .O_INSTRUCTION_POINTER, .O_COUNTER_LOW_BYTE, .O_TIMER_SRC_SEL, .O_PRESCALE_RATE, .O_TIMER_DIV_RATIO);

//--- bench/pcp_core_tb.sv
// self-checking bench for the program counter and paging core
`timescale 1ns/1ps
module pcp_core_tb;
  import pcp_pkg::*;
  logic        clk, rst_b, fw, src, edg, asg;
  pcp_op_e     op;
  logic [8:0]  ia, tdiv;
  logic [7:0]  res, w, st, fa, fd, lb, wdiv;
  logic [10:0] ip;
  logic [1:0]  bank;
  logic [2:0]  rate;
  int          err_count, comparisons;
  pcp_core dut (.I_CLK(clk), .I_RST_B(rst_b), .I_OP(op), .I_INSTR_ADDR(ia), .I_RESULT(res), .I_W_REG(w),
    .I_STATUS(st), .I_FILE_WR(fw), .I_FILE_ADDR(fa), .I_FILE_WDATA(fd), .O_INSTRUCTION_POINTER(ip),
    .O_COUNTER_LOW_BYTE(lb), .O_DATA_BANK(bank), .O_TIMER_SRC_SEL(src), .O_TIMER_EDGE_SEL(edg),
    .O_PRESCALER_ASSIGN(asg), .O_PRESCALE_RATE(rate), .O_TIMER_DIV_RATIO(tdiv), .O_WDOG_DIV_RATIO(wdiv));
  always #12.5 clk = ~clk;
  task conclude;
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input pcp_op_e o);
    op = o;
    @(posedge clk);
    #1;
  endtask
  initial begin
    #5000;
    err_count++;
    conclude;
  end
  initial begin
    clk = 0; rst_b = 0; fw = 0; ia = '0; res = '0; w = '0; st = '0; fa = '0; fd = '0;
    op = PCP_OP_NONE; err_count = 0; comparisons = 0;
    repeat (8) @(posedge clk);
    #1 rst_b = 1;
    chk(ip, 11'h7FF);
    chk({5'h00, src, edg, asg, rate}, 11'h03F);
    repeat (8) step(PCP_OP_NONE);
    st = 8'h60; ia = 9'h1FF; step(PCP_OP_JUMP); chk(ip, 11'h7FF);
    step(PCP_OP_NONE); chk(ip, 11'h000);
    st = 8'h20; ia = 9'h1AB; step(PCP_OP_CALL); chk(ip, 11'h2AB);
    chk({3'h0, lb}, 11'h0AB);
    st = 8'h40; res = 8'hCD; step(PCP_OP_LOWWR); chk(ip, 11'h4CD);
    st = 8'h00; fw = 1; fa = 8'h02; fd = 8'h5A; step(PCP_OP_NONE); chk(ip, 11'h05A);
    fa = 8'h04; fd = 8'h40; step(PCP_OP_NONE);
    fw = 0; step(PCP_OP_NONE); chk({9'h000, bank}, 11'h002);
    for (int i = 0; i < 8; i++) begin
      w = 8'hC0 | 8'(i * 9);
      step(PCP_OP_CFG);
      step(PCP_OP_NONE);
      chk({5'h00, src, edg, asg, rate}, {5'h00, w[5:0]});
      chk({2'h0, tdiv}, 11'h002 << i);
      chk({3'h0, wdiv}, 11'h001 << i);
    end
    conclude;
  end
endmodule
